// >>> core/nvsp_defs.vh
// timing and geometry constants for the nonvolatile sram host port
`ifndef NVSP_DEFS_VH
`define NVSP_DEFS_VH
`define NVSP_CLK_PERIOD_NS 100
`define NVSP_ADDR_W 11
`define NVSP_DATA_W 8
`define NVSP_DEPTH 2048
// fastest-grade figures in ns
`define NVSP_ADDRESS_ACCESS_TIME_NS 100
`define NVSP_T_OE_NS 50
`define NVSP_T_WP_NS 75
`define NVSP_T_DS_NS 40
`define NVSP_T_WR2_NS 10
`define NVSP_STROBE_TO_OUTPUT_OFF_NS 35
`define NVSP_T_RC_NS 100
`define NVSP_T_WC_NS 100
// supply monitoring, in us and ms
`define NVSP_T_PD_US 15
`define NVSP_T_PD_DIV 10
`define NVSP_PROTECT_RELEASE_TIME_MS 125
// minimum counts round up, never below one
`define NVSP_CYC_UP(ns) ((((ns) + `NVSP_CLK_PERIOD_NS - 1) / `NVSP_CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `NVSP_CLK_PERIOD_NS - 1) / `NVSP_CLK_PERIOD_NS))
`define NVSP_REC_CYCLES (`NVSP_PROTECT_RELEASE_TIME_MS * 1000000 / `NVSP_CLK_PERIOD_NS)
`endif

// >>> core/nvsp_delay_counter.v
// down-counter that times one strobe phase of the host sequencer
`timescale 1ns/10ps
`default_nettype none
module nvsp_delay_counter #(
    parameter integer WIDTH = 24
) (
    input wire clk_sys,
    input wire reset,
    input wire load,
    input wire [WIDTH-1:0] load_value,
    output wire done
);
    reg [WIDTH-1:0] count;

    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------
    // load wins over counting so a phase always gets its full length
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count <= {WIDTH{1'b0}};
        end else if (load) begin
            count <= load_value;
        end else if (count != {WIDTH{1'b0}}) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // count only: load is decoded from done, so gating with it would close a loop
    assign done = (count == {WIDTH{1'b0}});
endmodule
`default_nettype wire

// >>> core/nvsp_host.v
// host controller driving the byte-wide nonvolatile sram port
// What this block does
// - eleven address lines pick one of 2048 bytes, eight data lines.
// - address held unchanged for the whole write.
// - recovery after write before next cycle, 10 ns after select.
// - output enable held high throughout a write.
// - strobe/select overlap lasts at least 75 ns.
// - write data valid 40 ns before the write ends.
`timescale 1ns/10ps
`default_nettype none
`include "nvsp_defs.vh"
module nvsp_host #(
    parameter integer ADDRESS_ACCESS_TIME_NS = `NVSP_ADDRESS_ACCESS_TIME_NS,
    parameter integer T_OE_NS = `NVSP_T_OE_NS,
    parameter integer T_WP_NS = `NVSP_T_WP_NS,
    parameter integer T_DS_NS = `NVSP_T_DS_NS,
    parameter integer T_WR_NS = `NVSP_T_WR2_NS,
    parameter integer T_RC_NS = `NVSP_T_RC_NS,
    parameter integer T_WC_NS = `NVSP_T_WC_NS,
    parameter integer REC_CYCLES = `NVSP_REC_CYCLES
) (
    input wire clk_sys,
    input wire reset,
    // user side
    input wire req_valid,
    input wire req_write,
    input wire [`NVSP_ADDR_W-1:0] req_addr,
    input wire [`NVSP_DATA_W-1:0] req_wdata,
    output wire req_ready,
    output reg rsp_valid,
    output reg [`NVSP_DATA_W-1:0] rsp_rdata,
    input wire supply_ok,
    output reg write_protected,
    // device pins
    output reg [`NVSP_ADDR_W-1:0] byte_address_lines,
    output reg chip_select_n,
    output reg output_enable_n,
    output reg write_strobe_n,
    input wire [`NVSP_DATA_W-1:0] data_in,
    output reg [`NVSP_DATA_W-1:0] data_out,
    output reg data_oe
);
    localparam integer CW = 24;
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_RD = 3'd1;
    localparam [2:0] ST_WR_SET = 3'd2;
    localparam [2:0] ST_WR = 3'd3;
    localparam [2:0] ST_REC = 3'd4;

    // slowest read limit; address and select launch together with oe
    localparam integer RD_NS = (ADDRESS_ACCESS_TIME_NS > T_OE_NS) ? ADDRESS_ACCESS_TIME_NS : T_OE_NS;
    localparam integer WR_NS = (T_WP_NS > T_DS_NS) ? T_WP_NS : T_DS_NS;
    localparam integer RD_CYC = `NVSP_CYC_UP(RD_NS);
    localparam integer WP_CYC = `NVSP_CYC_UP(WR_NS);
    localparam integer WR_CYC = `NVSP_CYC_UP(T_WR_NS);
    localparam integer RC_CYC = `NVSP_CYC_UP(T_RC_NS);
    localparam integer PD_CYC = `NVSP_CYC_UP(`NVSP_T_PD_US * 1000 / `NVSP_T_PD_DIV);

    reg [2:0] state;
    reg [2:0] next_state;
    reg load;
    reg [CW-1:0] load_value;
    wire phase_done;
    reg [CW-1:0] rec_count;
    reg supply_seen;

    // converts a cycle count into the counter width
    function [CW-1:0] to_cnt;
        input integer cycles;
        begin
            to_cnt = cycles[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
        end
    endfunction

    nvsp_delay_counter #(
        .WIDTH(CW)
    ) u_phase (
        .clk_sys(clk_sys),
        .reset(reset),
        .load(load),
        .load_value(load_value),
        .done(phase_done)
    );

    // ---------------------------------------------------------------
    // supply lockout
    // ---------------------------------------------------------------
    // failure locks at once, well inside the lockout limit; release waits the full
    // recovery window since the device may stay protected that long
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            write_protected <= 1'b1;
            rec_count <= {CW{1'b0}};
            supply_seen <= 1'b0;
        end else if (!supply_ok) begin
            write_protected <= 1'b1;
            rec_count <= {CW{1'b0}};
            supply_seen <= 1'b0;
        end else if (!supply_seen) begin
            supply_seen <= 1'b1;
            rec_count <= REC_CYCLES[CW-1:0];
        end else if (rec_count != {CW{1'b0}}) begin
            rec_count <= rec_count - {{(CW-1){1'b0}}, 1'b1};
        end else begin
            write_protected <= 1'b0;
        end
    end

    assign req_ready = (state == ST_IDLE) && !write_protected && supply_ok;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always @* begin
        next_state = state;
        load = 1'b0;
        load_value = {CW{1'b0}};
        case (state)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    load = 1'b1;
                    if (req_write) begin
                        next_state = ST_WR_SET;
                        load_value = to_cnt(1);
                    end else begin
                        next_state = ST_RD;
                        load_value = to_cnt(RD_CYC);
                    end
                end
            end
            ST_RD: begin
                if (phase_done) begin
                    next_state = ST_REC;
                    load = 1'b1;
                    load_value = to_cnt((RC_CYC > RD_CYC) ? RC_CYC - RD_CYC : 1);
                end
            end
            ST_WR_SET: begin
                if (phase_done) begin
                    next_state = ST_WR;
                    load = 1'b1;
                    load_value = to_cnt(WP_CYC);
                end
            end
            ST_WR: begin
                if (phase_done) begin
                    next_state = ST_REC;
                    load = 1'b1;
                    load_value = to_cnt(WR_CYC);
                end
            end
            ST_REC: begin
                if (phase_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // supply failure aborts any cycle in progress
        if (!supply_ok && state != ST_IDLE && state != ST_REC) begin
            next_state = ST_REC;
            load = 1'b1;
            load_value = to_cnt(WR_CYC);
        end
    end

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // pins and response
    // ---------------------------------------------------------------
    // strobes come from flops; in a write select and strobe fall together and rise together, in a read select and oe do
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            byte_address_lines <= {`NVSP_ADDR_W{1'b0}};
            chip_select_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_strobe_n <= 1'b1;
            data_out <= {`NVSP_DATA_W{1'b0}};
            data_oe <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= {`NVSP_DATA_W{1'b0}};
        end else begin
            rsp_valid <= 1'b0;
            if (state == ST_IDLE && next_state == ST_RD) begin
                byte_address_lines <= req_addr;
                chip_select_n <= 1'b0;
                output_enable_n <= 1'b0;
                write_strobe_n <= 1'b1;
            end
            if (state == ST_IDLE && next_state == ST_WR_SET) begin
                byte_address_lines <= req_addr;
                data_out <= req_wdata;
                data_oe <= 1'b1;
                output_enable_n <= 1'b1;
            end
            if (state == ST_WR_SET && next_state == ST_WR) begin
                chip_select_n <= 1'b0;
                write_strobe_n <= 1'b0;
            end
            if (state == ST_RD && next_state == ST_REC && phase_done) begin
                rsp_rdata <= data_in;
                rsp_valid <= 1'b1;
            end
            if (next_state == ST_REC && state != ST_REC) begin
                chip_select_n <= 1'b1;
                write_strobe_n <= 1'b1;
                output_enable_n <= 1'b1;
            end
            // data held one recovery phase past the end as hold margin
            if (state == ST_REC && phase_done) begin
                data_oe <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/nvsp_host_sva.sv
// pin-level assertions for the sram host port
`timescale 1ns/10ps
`default_nettype none
module nvsp_host_sva (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic supply_ok,
    input wire logic [10:0] byte_address_lines,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    // one clock domain, so one default for all
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_addr_hold: assert property (!chip_select_n && !write_strobe_n |-> $stable(byte_address_lines))
        else $error("address moved during write");
    chk_oe_write: assert property (data_oe || !write_strobe_n |-> output_enable_n)
        else $error("output enable low while writing");
    chk_read_mode: assert property (!output_enable_n |-> write_strobe_n && !chip_select_n)
        else $error("output enable low outside a read");
    chk_pulse_overlap: assert property ($fell(write_strobe_n) |-> !chip_select_n)
        else $error("strobe fell without select");
    chk_data_setup: assert property (!write_strobe_n |-> data_oe && $stable(data_out))
        else $error("write data not set up");
    chk_recovery_gap: assert property ($rose(chip_select_n) |=> chip_select_n)
        else $error("no recovery after select rose");
    chk_read_sample: assert property (rsp_valid |-> !$past(chip_select_n) && !$past(output_enable_n))
        else $error("read answered without access");
    chk_supply_lock: assert property (!supply_ok |-> ##[0:15] (chip_select_n && write_strobe_n && !req_ready))
        else $error("strobes active after supply loss");
endmodule
bind nvsp_host nvsp_host_sva nvsp_host_sva_i (.clk_sys(clk_sys), .reset(reset), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .supply_ok(supply_ok), .byte_address_lines(byte_address_lines),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// >>> test/nvsp_sram_model.sv
// behavioural 2048 x 8 nonvolatile sram
`timescale 1ns/10ps
`default_nettype none
module nvsp_sram_model #(
    parameter integer ADDRESS_ACCESS_TIME_NS = 100
) (
    input wire logic [10:0] addr,
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic powered,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_drive
);
    logic [7:0] mem [0:2047];
    logic good = 1'b0;
    wire wr_on = powered && !cs_n && !we_n;
    wire rd_on = powered && !cs_n && !oe_n && we_n;
    // store at the earlier rise; a failed supply loses it
    always @(negedge wr_on) begin
        if (powered) begin
            mem[addr] = dq_in;
        end
    end
    // valid only after the slowest access path
    always @(rd_on or addr) begin
        good = 1'b0;
        good <= #(ADDRESS_ACCESS_TIME_NS) rd_on;
    end
    // drivers off at once; undriven shows the inverse
    assign dq_drive = rd_on;
    assign dq_out = good && rd_on ? mem[addr] : ~mem[addr];
endmodule
`default_nettype wire

// >>> test/nvsp_host_tb.sv
// self-checking bench for the sram host port
`timescale 1ns/10ps
`default_nettype none
`define NVSP_CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module nvsp_host_tb;
    localparam integer REC = 20;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic supply_ok = 1'b1;
    logic [10:0] req_addr = 11'h000;
    logic [7:0] req_wdata = 8'h00;
    wire req_ready, rsp_valid, write_protected, chip_select_n, output_enable_n, write_strobe_n, data_oe, dev_drive;
    wire [7:0] rsp_rdata, data_out, dev_q, bus;
    wire [10:0] byte_address_lines;
    integer miscompares = 0;
    integer checks_done = 0;
    // host wins only when the device is off
    assign bus = data_oe && !dev_drive ? data_out : dev_q;
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    nvsp_host #(.REC_CYCLES(REC)) nvsp_host_i (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .supply_ok(supply_ok), .write_protected(write_protected),
        .byte_address_lines(byte_address_lines), .chip_select_n(chip_select_n),
        .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n), .data_in(bus),
        .data_out(data_out), .data_oe(data_oe));
    nvsp_sram_model #(.ADDRESS_ACCESS_TIME_NS(95)) nvsp_sram_model_i (.addr(byte_address_lines), .cs_n(chip_select_n),
        .oe_n(output_enable_n), .we_n(write_strobe_n), .powered(supply_ok), .dq_in(bus),
        .dq_out(dev_q), .dq_drive(dev_drive));
    task automatic report_and_stop;
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one request held until taken; e is the byte expected afterwards
    task automatic xfer(input logic wr, input logic [10:0] a, input logic [7:0] d, input logic [7:0] e);
        integer n;
        n = 0;
        @(posedge clk_sys);
        #1;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        // ready is looked at between edges, then the request stands through the taking edge
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
        // a write ends when ready returns, or when a supply cut locks the port
        while ((wr ? (req_ready || write_protected) : rsp_valid) !== 1'b1 && n < 80) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        `NVSP_CHECK(n < 80, 1'b1)
        `NVSP_CHECK(wr ? nvsp_sram_model_i.mem[a] : rsp_rdata, e)
    endtask
    // protection must outlast the recovery count
    task automatic wait_release;
        integer n;
        n = 0;
        `NVSP_CHECK({req_ready, write_protected}, 2'b01)
        while (write_protected !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        `NVSP_CHECK(n >= REC && n <= REC + 3, 1'b1)
    endtask
    // corner addresses back to back, read back in reverse
    task automatic sc_edges;
        logic [10:0] at [4];
        logic [7:0] dt [4];
        at = '{11'h000, 11'h7ff, 11'h2aa, 11'h555};
        dt = '{8'ha5, 8'hff, 8'h5a, 8'h00};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, at[i], dt[i], dt[i]);
        end
        for (int i = 3; i >= 0; i--) begin
            xfer(1'b0, at[i], 8'h00, dt[i]);
        end
    endtask
    // supply dies with the strobe low: old byte survives
    task automatic sc_supply_cut;
        fork
            xfer(1'b1, 11'h2aa, 8'h3c, 8'h5a);
            begin
                // third edge launches the strobes; cut while they are low
                repeat (3) @(posedge clk_sys);
                #1;
                supply_ok = 1'b0;
            end
        join
        supply_ok = 1'b1;
        wait_release;
        xfer(1'b0, 11'h2aa, 8'h00, 8'h5a);
    endtask
    initial begin
        #(100 * 3000);
        miscompares++;
        report_and_stop;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        wait_release;
        sc_edges;
        sc_supply_cut;
        report_and_stop;
    end
endmodule
`default_nettype wire
